/* File: core/sbmx_block_move.sv */
// Block move executor: script fetch, phase check and byte mover
//
// Implementation choices: the address map and register access over APB.
module sbmx_block_move (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System memory master
  output logic mem_req,
  output logic mem_wr,
  output logic [31:0] mem_addr,
  output logic [3:0] mem_be,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // SCSI initiator pins
  input wire logic scsi_req,
  input wire logic scsi_msg,
  input wire logic scsi_cd,
  input wire logic scsi_io,
  input wire logic [15:0] scsi_data_in,
  output logic [15:0] scsi_data_out,
  output logic scsi_data_oe,
  output logic scsi_ack
);

  // Byte of a word chosen by the low address bits
  function automatic logic [7:0] lane_byte(logic [31:0] w, logic [1:0] a);
    return w[{a, 3'h0} +: 8];
  endfunction

  // Pin synchroniser and agreed values
  logic [sbmx_pkg::SYNC_W-1:0] s1_q, s2_q, s3_q, stab_q, stab_d;
  logic [sbmx_pkg::SYNC_W-1:0] s1_d, s2_d, s3_d;
  logic req_s;
  logic [2:0] ph_s;
  logic [15:0] dat_s;

  // A pin change counts only once the second and third stages agree
  always_comb
  begin
    s1_d = {scsi_req, scsi_msg, scsi_cd, scsi_io, scsi_data_in};
    s2_d = s1_q;
    s3_d = s2_q;
    stab_d = (stab_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= sbmx_pkg::RST_SYNC;
      s2_q <= sbmx_pkg::RST_SYNC;
      s3_q <= sbmx_pkg::RST_SYNC;
      stab_q <= sbmx_pkg::RST_SYNC;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      stab_q <= stab_d;
    end
  end

  assign req_s = stab_q[19];
  assign ph_s = stab_q[18:16];
  assign dat_s = stab_q[15:0];

  // APB slave: one wait state, answer from flops
  logic pready_d, pslverr_d;
  logic [31:0] prdata_d;
  logic apb_wr, apb_start, map_hit;

  // Engine state
  sbmx_pkg::sbmx_state_type st_q, st_d;
  logic [31:0] dsp_q, dsp_d, data_structure_base_q, data_structure_base_d;
  logic [31:0] script_pointer_save_q, script_pointer_save_d;
  logic [31:0] next_data_address_q, next_data_address_d;
  logic [7:0] dma_command_reg_q, dma_command_reg_d;
  logic [23:0] dma_byte_counter_q, dma_byte_counter_d;
  logic [2:0] scsi_phase_status_q, scsi_phase_status_d;
  logic req_seen_q, req_seen_d;
  logic [15:0] buf_q, buf_d;
  logic [1:0] nbuf_q, nbuf_d;
  logic mism_q, mism_d, ill_q, ill_d, late_q, late_d;
  logic [2:0] io_op_q, io_op_d;
  logic [9:0] ovh_q, ovh_d;
  logic mem_req_d, mem_wr_d;
  logic [31:0] mem_addr_d, mem_wdata_d;
  logic [3:0] mem_be_d;
  logic [15:0] dout_d;
  logic doe_d, ack_d;
  logic [31:0] stat_w;
  logic chained, dir_in, pend, ph_ok, mem_done;
  logic [2:0] ph_now;

  assign stat_w = {18'h0_0000, late_q, io_op_q, nbuf_q, st_q == sbmx_pkg::ST_HALT,
    ill_q, mism_q, st_q != sbmx_pkg::ST_IDLE && st_q != sbmx_pkg::ST_HALT,
    1'b0, scsi_phase_status_q};

  // Register decode and read mux
  always_comb
  begin
    map_hit = paddr <= sbmx_pkg::OFS_STAT && paddr[1:0] == 2'h0;
    pready_d = psel && penable && !pready;
    pslverr_d = pready_d && !map_hit;
    apb_wr = psel && penable && pready && pwrite && !pslverr;
    apb_start = apb_wr && paddr == sbmx_pkg::OFS_CTRL && pwdata[0];
    prdata_d = prdata;
    if (pready_d && !pwrite)
    begin
      unique case (paddr)
        sbmx_pkg::OFS_DSP: prdata_d = dsp_q;
        sbmx_pkg::OFS_BASE: prdata_d = data_structure_base_q;
        sbmx_pkg::OFS_CMD: prdata_d = {dma_command_reg_q, dma_byte_counter_q};
        sbmx_pkg::OFS_SAVE: prdata_d = script_pointer_save_q;
        sbmx_pkg::OFS_NEXT: prdata_d = next_data_address_q;
        sbmx_pkg::OFS_STAT: prdata_d = stat_w;
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= sbmx_pkg::RST_WORD;
    end
    else
    begin
      pready <= pready_d;
      pslverr <= pslverr_d;
      prdata <= prdata_d;
    end
  end

  // Engine next state
  always_comb
  begin
    st_d = st_q;
    dsp_d = dsp_q;
    data_structure_base_d = data_structure_base_q;
    script_pointer_save_d = script_pointer_save_q;
    next_data_address_d = next_data_address_q;
    dma_command_reg_d = dma_command_reg_q;
    dma_byte_counter_d = dma_byte_counter_q;
    scsi_phase_status_d = scsi_phase_status_q;
    buf_d = buf_q;
    nbuf_d = nbuf_q;
    mism_d = mism_q;
    ill_d = ill_q;
    late_d = late_q;
    io_op_d = io_op_q;
    ovh_d = ovh_q;
    mem_req_d = mem_req;
    mem_wr_d = mem_wr;
    mem_addr_d = mem_addr;
    mem_be_d = mem_be;
    mem_wdata_d = mem_wdata;
    dout_d = scsi_data_out;
    doe_d = scsi_data_oe;
    ack_d = scsi_ack;
    req_seen_d = req_s;
    chained = !dma_command_reg_q[sbmx_pkg::BIT_MOVE - 24];
    dir_in = dma_command_reg_q[0];
    mem_done = mem_req && mem_ack;
    // A REQ not yet answered by ACK is a phase awaiting service
    pend = req_s && !scsi_ack;
    // A phase latched in this very cycle is compared at once, never the stale one
    ph_now = req_s && !req_seen_q ? ph_s : scsi_phase_status_q;
    ph_ok = ph_now == dma_command_reg_q[2:0];
    // Phase lines taken only on the REQ rising edge
    if (req_s && !req_seen_q)
      scsi_phase_status_d = ph_s;
    if (apb_wr && paddr == sbmx_pkg::OFS_DSP)
      dsp_d = pwdata;
    if (apb_wr && paddr == sbmx_pkg::OFS_BASE)
      data_structure_base_d = pwdata;
    // Fetch cycles count toward the per segment overhead
    if (st_q inside {sbmx_pkg::ST_F0, sbmx_pkg::ST_F1, sbmx_pkg::ST_DEC,
        sbmx_pkg::ST_IND, sbmx_pkg::ST_TCNT, sbmx_pkg::ST_TADR} && ovh_q != 10'h3ff)
      ovh_d = ovh_q + 10'h001;
    if (mem_done)
      mem_req_d = 1'b0;
    unique case (st_q)
      sbmx_pkg::ST_IDLE, sbmx_pkg::ST_HALT:
      begin
        ovh_d = 10'h000;
        if (apb_start)
        begin
          mism_d = 1'b0;
          ill_d = 1'b0;
          st_d = sbmx_pkg::ST_F0;
        end
      end
      sbmx_pkg::ST_F0:
        if (!mem_req)
        begin
          mem_req_d = 1'b1;
          mem_wr_d = 1'b0;
          mem_be_d = 4'hf;
          mem_addr_d = dsp_q;
        end
        else if (mem_ack)
        begin
          dma_command_reg_d = mem_rdata[31:24];
          dma_byte_counter_d = mem_rdata[23:0];
          st_d = sbmx_pkg::ST_F1;
        end
      sbmx_pkg::ST_F1:
        if (!mem_req)
        begin
          mem_req_d = 1'b1;
          mem_addr_d = dsp_q + 32'h0000_0004;
        end
        else if (mem_ack)
        begin
          script_pointer_save_d = mem_rdata;
          dsp_d = dsp_q + 32'h0000_0008;
          st_d = sbmx_pkg::ST_DEC;
        end
      sbmx_pkg::ST_DEC:
      begin
        st_d = sbmx_pkg::ST_HALT;
        if (dma_command_reg_q[7:6] == sbmx_pkg::OPC_MOVE)
        begin
          if (dma_command_reg_q[5] && dma_command_reg_q[4])
            ill_d = 1'b1;
          else if (dma_command_reg_q[sbmx_pkg::BIT_TBL - 24])
          begin
            // Second word is a signed offset from the structure base
            next_data_address_d = data_structure_base_q
              + {{8{script_pointer_save_q[23]}}, script_pointer_save_q[23:0]};
            st_d = sbmx_pkg::ST_TCNT;
          end
          else if (dma_command_reg_q[sbmx_pkg::BIT_IND - 24])
            st_d = sbmx_pkg::ST_IND;
          else
          begin
            next_data_address_d = script_pointer_save_q;
            st_d = sbmx_pkg::ST_WPH;
            late_d = late_q | (ovh_q > sbmx_pkg::OVH_DIR_CYC);
          end
        end
        else if (dma_command_reg_q[7:6] == sbmx_pkg::OPC_IO)
          io_op_d = dma_command_reg_q[5:3];
        else
          ill_d = 1'b1;
      end
      sbmx_pkg::ST_IND:
        if (!mem_req)
        begin
          mem_req_d = 1'b1;
          mem_addr_d = script_pointer_save_q;
        end
        else if (mem_ack)
        begin
          script_pointer_save_d = mem_rdata;
          next_data_address_d = mem_rdata;
          st_d = sbmx_pkg::ST_WPH;
          late_d = late_q | (ovh_q > sbmx_pkg::OVH_IND_CYC);
        end
      sbmx_pkg::ST_TCNT:
        if (!mem_req)
        begin
          mem_req_d = 1'b1;
          mem_addr_d = next_data_address_q;
        end
        else if (mem_ack)
        begin
          dma_byte_counter_d = mem_rdata[23:0];
          st_d = sbmx_pkg::ST_TADR;
        end
      sbmx_pkg::ST_TADR:
        if (!mem_req)
        begin
          mem_req_d = 1'b1;
          mem_addr_d = next_data_address_q + 32'h0000_0004;
        end
        else if (mem_ack)
        begin
          next_data_address_d = mem_rdata;
          st_d = sbmx_pkg::ST_WPH;
          late_d = late_q | (ovh_q > sbmx_pkg::OVH_IND_CYC);
        end
      sbmx_pkg::ST_WPH:
        if (pend)
        begin
          // Count and address stay put so software can resume
          if (!ph_ok)
          begin
            mism_d = 1'b1;
            st_d = sbmx_pkg::ST_HALT;
          end
          else
            st_d = sbmx_pkg::ST_XFER;
        end
      sbmx_pkg::ST_XFER:
      begin
        ovh_d = 10'h000;
        if (!dir_in)
        begin
          if (dma_byte_counter_q != 24'h00_0000 && nbuf_q != 2'h2)
            st_d = sbmx_pkg::ST_MRD;
          else if (nbuf_q == 2'h2 || (!chained && nbuf_q == 2'h1))
            st_d = sbmx_pkg::ST_SOUT;
          else
            st_d = sbmx_pkg::ST_F0;
        end
        else if (dma_byte_counter_q != 24'h00_0000)
          st_d = nbuf_q != 2'h0 ? sbmx_pkg::ST_MWR : sbmx_pkg::ST_SIN;
        else
        begin
          // Residue of a wide transfer is dropped on a normal move
          if (!chained)
            nbuf_d = 2'h0;
          st_d = sbmx_pkg::ST_F0;
        end
      end
      sbmx_pkg::ST_MRD:
        if (!mem_req)
        begin
          mem_req_d = 1'b1;
          mem_wr_d = 1'b0;
          mem_addr_d = {next_data_address_q[31:2], 2'h0};
          mem_be_d = 4'h1 << next_data_address_q[1:0];
        end
        else if (mem_ack)
        begin
          // A held odd byte fills the low lane first
          if (nbuf_q == 2'h0)
            buf_d[7:0] = lane_byte(mem_rdata, next_data_address_q[1:0]);
          else
            buf_d[15:8] = lane_byte(mem_rdata, next_data_address_q[1:0]);
          nbuf_d = nbuf_q + 2'h1;
          dma_byte_counter_d = dma_byte_counter_q - 24'h00_0001;
          next_data_address_d = next_data_address_q + 32'h0000_0001;
          st_d = sbmx_pkg::ST_XFER;
        end
      sbmx_pkg::ST_MWR:
        if (!mem_req)
        begin
          mem_req_d = 1'b1;
          mem_wr_d = 1'b1;
          mem_addr_d = {next_data_address_q[31:2], 2'h0};
          mem_be_d = 4'h1 << next_data_address_q[1:0];
          mem_wdata_d = {4{buf_q[7:0]}};
        end
        else if (mem_ack)
        begin
          buf_d = {8'h00, buf_q[15:8]};
          nbuf_d = nbuf_q - 2'h1;
          dma_byte_counter_d = dma_byte_counter_q - 24'h00_0001;
          next_data_address_d = next_data_address_q + 32'h0000_0001;
          mem_wr_d = 1'b0;
          st_d = sbmx_pkg::ST_XFER;
        end
      sbmx_pkg::ST_SOUT, sbmx_pkg::ST_SIN:
        if (pend)
        begin
          if (!ph_ok)
          begin
            mism_d = 1'b1;
            st_d = sbmx_pkg::ST_HALT;
          end
          else
          begin
            if (st_q == sbmx_pkg::ST_SOUT)
            begin
              // A lone byte goes out with a zero high lane
              dout_d = nbuf_q == 2'h1 ? {8'h00, buf_q[7:0]} : buf_q;
              doe_d = 1'b1;
              nbuf_d = 2'h0;
            end
            else
            begin
              buf_d = dat_s;
              nbuf_d = 2'h2;
            end
            ack_d = 1'b1;
            st_d = sbmx_pkg::ST_SACK;
          end
        end
      sbmx_pkg::ST_SACK:
        if (!req_s)
        begin
          ack_d = 1'b0;
          doe_d = 1'b0;
          st_d = sbmx_pkg::ST_XFER;
        end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= sbmx_pkg::ST_IDLE;
      dsp_q <= sbmx_pkg::RST_WORD;
      data_structure_base_q <= sbmx_pkg::RST_WORD;
      script_pointer_save_q <= sbmx_pkg::RST_WORD;
      next_data_address_q <= sbmx_pkg::RST_WORD;
      dma_command_reg_q <= sbmx_pkg::RST_CMD;
      dma_byte_counter_q <= sbmx_pkg::RST_CNT;
      scsi_phase_status_q <= 3'h0;
      req_seen_q <= 1'b0;
      buf_q <= 16'h0000;
      nbuf_q <= 2'h0;
      mism_q <= 1'b0;
      ill_q <= 1'b0;
      late_q <= 1'b0;
      io_op_q <= 3'h0;
      ovh_q <= 10'h000;
      mem_req <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= sbmx_pkg::RST_WORD;
      mem_be <= 4'h0;
      mem_wdata <= sbmx_pkg::RST_WORD;
      scsi_data_out <= 16'h0000;
      scsi_data_oe <= 1'b0;
      scsi_ack <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      dsp_q <= dsp_d;
      data_structure_base_q <= data_structure_base_d;
      script_pointer_save_q <= script_pointer_save_d;
      next_data_address_q <= next_data_address_d;
      dma_command_reg_q <= dma_command_reg_d;
      dma_byte_counter_q <= dma_byte_counter_d;
      scsi_phase_status_q <= scsi_phase_status_d;
      req_seen_q <= req_seen_d;
      buf_q <= buf_d;
      nbuf_q <= nbuf_d;
      mism_q <= mism_d;
      ill_q <= ill_d;
      late_q <= late_d;
      io_op_q <= io_op_d;
      ovh_q <= ovh_d;
      mem_req <= mem_req_d;
      mem_wr <= mem_wr_d;
      mem_addr <= mem_addr_d;
      mem_be <= mem_be_d;
      mem_wdata <= mem_wdata_d;
      scsi_data_out <= dout_d;
      scsi_data_oe <= doe_d;
      scsi_ack <= ack_d;
    end
  end

endmodule

/* File: inc/sbmx_pkg.sv */
// Constants, offsets and states of the block move executor
package sbmx_pkg;
  // Register offsets on the APB (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DSP = 8'h04;
  localparam logic [7:0] OFS_BASE = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_SAVE = 8'h10;
  localparam logic [7:0] OFS_NEXT = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [23:0] RST_CNT = 24'h00_0000;
  localparam logic [7:0] RST_CMD = 8'h00;
  // Instruction fields (bit positions in the first word)
  localparam int BIT_IND = 29;
  localparam int BIT_TBL = 28;
  localparam int BIT_MOVE = 27;
  localparam logic [1:0] OPC_MOVE = 2'h0;
  localparam logic [1:0] OPC_IO = 2'h1;
  // Bus phase codes {msg, c/d, i/o}
  localparam logic [2:0] PH_DOUT = 3'h0;
  localparam logic [2:0] PH_DIN = 3'h1;
  localparam logic [2:0] PH_CMD = 3'h2;
  localparam logic [2:0] PH_STAT = 3'h3;
  localparam logic [2:0] PH_RSVO = 3'h4;
  localparam logic [2:0] PH_RSVI = 3'h5;
  localparam logic [2:0] PH_MOUT = 3'h6;
  localparam logic [2:0] PH_MIN = 3'h7;
  // Switching overhead limits per segment
  localparam int CLK_NS = 10;
  localparam int OVH_DIR_NS = 500;
  localparam int OVH_IND_NS = 750;
  localparam logic [9:0] OVH_DIR_CYC = 10'(OVH_DIR_NS / CLK_NS);
  localparam logic [9:0] OVH_IND_CYC = 10'(OVH_IND_NS / CLK_NS);
  // Pin synchroniser width: req, msg, cd, io, data
  localparam int SYNC_W = 20;
  localparam logic [SYNC_W-1:0] RST_SYNC = 20'h0_0000;
  // Engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_F0, ST_F1, ST_DEC, ST_IND, ST_TCNT, ST_TADR, ST_WPH,
    ST_XFER, ST_MRD, ST_MWR, ST_SOUT, ST_SIN, ST_SACK, ST_HALT
  } sbmx_state_type;
endpackage

/* File: verification/sbmx_monitor.sv */
// Port checker for the block move executor
module sbmx_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Memory master
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic [31:0] mem_wdata,
  // SCSI pins
  input wire logic scsi_req,
  input wire logic scsi_io,
  input wire logic scsi_ack,
  input wire logic scsi_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // REQ must have crossed the synchroniser before ACK answers it
  property p_ack_after_req;
    $rose(scsi_ack) |-> scsi_req && $past(scsi_req, 2) && $past(scsi_req, 3);
  endproperty
  a_ack_after_req: assert property (p_ack_after_req) else $error("early ack");
  // Data is driven only in out phases
  property p_oe_out_only;
    scsi_data_oe |-> !scsi_io;
  endproperty
  a_oe_out_only: assert property (p_oe_out_only) else $error("drive in in-phase");
  // ACK cannot outlive a released REQ
  property p_ack_release;
    !scsi_req [*6] |-> !scsi_ack;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack stuck");
  // Out data goes with ACK
  property p_oe_with_ack;
    $rose(scsi_data_oe) |-> scsi_ack;
  endproperty
  a_oe_with_ack: assert property (p_oe_with_ack) else $error("oe without ack");
  // A memory request holds still until answered
  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wr);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("request moved");
  // Request drops after the answer
  property p_mem_drop;
    mem_req && mem_ack |=> !mem_req;
  endproperty
  a_mem_drop: assert property (p_mem_drop) else $error("request kept");
  // One data byte per write, replicated on all lanes
  property p_wr_byte;
    mem_req && mem_wr |-> $onehot(mem_be) && mem_wdata == {4{mem_wdata[7:0]}};
  endproperty
  a_wr_byte: assert property (p_wr_byte) else $error("bad byte write");
  // Exactly one wait state on APB
  property p_apb_wait;
    psel && $rose(penable) |-> !pready ##1 pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb timing");
  // Error only with ready
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("stray error");
endmodule

/* File: verification/sbmx_scsi_target.sv */
// Behavioural SCSI target facing the initiator pins
module sbmx_scsi_target (
  // Clock and scenario control
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [2:0] phase,
  input wire logic [3:0] dly,
  input wire logic [15:0] tx_word,
  // SCSI pins
  input wire logic scsi_ack,
  input wire logic [15:0] scsi_data_out,
  input wire logic scsi_data_oe,
  output logic scsi_req,
  output logic scsi_msg,
  output logic scsi_cd,
  output logic scsi_io,
  output logic [15:0] scsi_data_in,
  // Words seen on ACK
  output logic rx_stb,
  output logic [15:0] rx_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // One REQ/ACK exchange per loop; REQ waits as long as ACK takes
  initial
  begin
    scsi_req = 1'b0;
    {scsi_msg, scsi_cd, scsi_io} = 3'b000;
    scsi_data_in = 16'h0000;
    rx_stb = 1'b0;
    rx_word = 16'h0000;
    forever
    begin
      @(posedge ref_clk);
      rx_stb <= 1'b0;
      if (go)
      begin
        // Phase settles before REQ so the latch sees a clean value
        {scsi_msg, scsi_cd, scsi_io} <= phase;
        repeat (dly + 1) @(posedge ref_clk);
        scsi_data_in <= tx_word;
        scsi_req <= 1'b1;
        while (go && !scsi_ack)
          @(posedge ref_clk);
        rx_word <= scsi_data_out;
        rx_stb <= scsi_ack & scsi_data_oe;
        scsi_req <= 1'b0;
        // Released bus shows the inverse, not a stale copy
        scsi_data_in <= ~tx_word;
        while (scsi_ack)
        begin
          @(posedge ref_clk);
          rx_stb <= 1'b0;
        end
      end
    end
  end
endmodule

/* File: verification/sbmx_block_move_tb.sv */
// Self-checking bench for the block move executor
module sbmx_block_move_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [32:0] SM = 33'h1_0000_3fff;
  localparam logic [32:0] FM = 33'h1_ffff_ffff;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, go, rx_stb;
  logic mem_req, mem_wr, mem_ack, scsi_req, scsi_msg, scsi_cd, scsi_io, scsi_data_oe, scsi_ack;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, r;
  logic [3:0] mem_be, dly;
  logic [2:0] phase;
  logic [15:0] scsi_data_in, scsi_data_out, tx_word, rx_word, seed, mseed;
  logic [31:0] mem [0:255];
  logic [65:0] note;
  logic [65:0] aq[$];
  logic [15:0] sq[$];
  int failures, check_count, cyc;

  sbmx_block_move sbmx_block_move_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .scsi_req(scsi_req), .scsi_msg(scsi_msg), .scsi_cd(scsi_cd),
    .scsi_io(scsi_io), .scsi_data_in(scsi_data_in), .scsi_data_out(scsi_data_out),
    .scsi_data_oe(scsi_data_oe), .scsi_ack(scsi_ack));
  sbmx_scsi_target sbmx_scsi_target_i (.ref_clk(ref_clk), .go(go), .phase(phase), .dly(dly),
    .tx_word(tx_word), .scsi_ack(scsi_ack), .scsi_data_out(scsi_data_out),
    .scsi_data_oe(scsi_data_oe), .scsi_req(scsi_req), .scsi_msg(scsi_msg),
    .scsi_cd(scsi_cd), .scsi_io(scsi_io), .scsi_data_in(scsi_data_in), .rx_stb(rx_stb),
    .rx_word(rx_word));

  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [32:0] st(input logic [2:0] op, input logic mis, input logic ill,
    input logic [2:0] ph);
    return {20'h0_0000, op, 2'b00, 1'b1, ill, mis, 2'b00, ph};
  endfunction

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Setup, then access held until pready; an idle edge follows
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    // A slave that never answers counts against the run
    if (pready !== 1'b1)
      failures++;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    aq.push_back({e, m});
    apb(1'b0, a, 32'h0);
  endtask

  // Start the script and poll until the engine stops; the target is slow or prompt at random
  task automatic scen(input logic [2:0] ph, input logic [31:0] dsp);
    int n;
    n = 0;
    phase <= ph;
    dly <= seed[3:0];
    go <= 1'b1;
    apb(1'b1, sbmx_pkg::OFS_DSP, dsp);
    apb(1'b1, sbmx_pkg::OFS_CTRL, 32'h0000_0001);
    do
    begin
      rd(sbmx_pkg::OFS_STAT, 33'h0, 33'h0);
      n++;
    end
    while ((r[4] !== 1'b0 || r[7] !== 1'b1) && n < 200);
    if (r[4] !== 1'b0 || r[7] !== 1'b1)
      failures++;
    go <= 1'b0;
    repeat (10) @(posedge ref_clk);
  endtask

  task automatic post(input logic [32:0] s, input logic [31:0] cmd, input logic [31:0] nxt);
    rd(sbmx_pkg::OFS_STAT, s, SM);
    rd(sbmx_pkg::OFS_CMD, {1'b0, cmd}, FM);
    rd(sbmx_pkg::OFS_NEXT, {1'b0, nxt}, FM);
  endtask

  // Memory slave with random latency; idle read bus toggles
  always @(posedge ref_clk)
  begin
    mseed <= lfsr(mseed);
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req === 1'b1 && !mem_ack && mseed[0])
    begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[9:2]];
      for (int b = 0; b < 4; b++)
        if (mem_wr && mem_be[b])
          mem[mem_addr[9:2]][8*b+:8] <= mem_wdata[8*b+:8];
    end
  end

  // Oldest notes against read answers and target words; cycle ceiling
  always @(posedge ref_clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && aq.size() > 0)
    begin
      note = aq.pop_front();
      if (note[32:0] != 33'h0)
        chk({pslverr, prdata} & note[32:0], note[65:33] & note[32:0]);
    end
    if (rx_stb === 1'b1)
      chk({17'h0, rx_word}, sq.size() > 0 ? {17'h0, sq.pop_front()} : 33'hx);
    cyc++;
    if (cyc == 30000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  initial
  begin
    {nrst, psel, penable, pwrite, go} = 5'h00;
    {paddr, pwdata, mem_rdata, phase, dly, tx_word} = '0;
    {failures, check_count, cyc} = '0;
    seed = 16'h0061;
    mseed = 16'h0061;
    for (int i = 0; i < 256; i++)
      mem[i] = 32'h0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    // Reset value and an unmapped place
    rd(sbmx_pkg::OFS_CMD, 33'h0, FM);
    rd(8'h40, 33'h1_0000_0000, FM);
    // Indirect data-out of two bytes as one wide word
    seed = lfsr(seed);
    mem[8'h80] = {16'h0, seed};
    mem[8'h40] = 32'h0000_0200;
    mem[0] = 32'h2800_0002;
    mem[1] = 32'h0000_0100;
    mem[2] = 32'h6800_0000;
    mem[3] = 32'h0000_0a5c;
    sq.push_back(seed);
    scen(3'd0, 32'h0);
    post(st(3'd5, 1'b0, 1'b0, 3'd0), 32'h6800_0000, 32'h0000_0202);
    rd(sbmx_pkg::OFS_SAVE, 33'h0_0000_0a5c, FM);
    // Chained lone byte paired with the next move, whose odd end is flushed
    seed = lfsr(seed);
    mem[8'h84] = {24'h0, ~seed[7:0]};
    mem[8'h85] = {16'h0, seed};
    mem[4] = 32'h0000_0001;
    mem[5] = 32'h0000_0210;
    mem[6] = 32'h0800_0002;
    mem[7] = 32'h0000_0214;
    mem[8] = 32'h5000_0000;
    sq.push_back({seed[7:0], ~seed[7:0]});
    sq.push_back({8'h00, seed[15:8]});
    scen(3'd0, 32'h10);
    post(st(3'd2, 1'b0, 1'b0, 3'd0), 32'h5000_0000, 32'h0000_0216);
    // Table indirect data-in of three bytes through a negative offset; residue dropped
    seed = lfsr(seed);
    tx_word <= seed;
    mem[8'hc2] = 32'h0000_0003;
    mem[8'hc3] = 32'h0000_0220;
    mem[16] = 32'h1900_0002;
    mem[17] = 32'h00ff_fff8;
    mem[18] = 32'h7800_0000;
    apb(1'b1, sbmx_pkg::OFS_BASE, 32'h0000_0310);
    scen(3'd1, 32'h40);
    post(st(3'd7, 1'b0, 1'b0, 3'd1), 32'h7800_0000, 32'h0000_0223);
    chk({9'h0, mem[8'h88][23:0]}, {9'h0, seed[7:0], seed});
    // Mismatch on every phase code keeps count and address
    for (int p = 0; p < 8; p++)
    begin
      mem[24] = {5'b00001, ~p[2:0], 24'h00_0004};
      mem[25] = 32'h0000_0230;
      scen(p[2:0], 32'h60);
      post(st(3'd7, 1'b1, 1'b0, p[2:0]), mem[24], 32'h0000_0230);
    end
    // Indirect and table bits together
    mem[26] = 32'h3800_0001;
    mem[27] = 32'h0000_0240;
    scen(3'd7, 32'h68);
    rd(sbmx_pkg::OFS_STAT, st(3'd7, 1'b0, 1'b1, 3'd7), SM);
    // Every I/O operation code is recorded and stops the engine
    for (int op = 0; op < 8; op++)
    begin
      mem[28] = {2'b01, op[2:0], 27'h0};
      scen(3'd7, 32'h70);
      rd(sbmx_pkg::OFS_STAT, st(op[2:0], 1'b0, 1'b0, 3'd7), SM);
    end
    // Every word expected at the target was seen there
    chk(33'(sq.size()), 33'h0);
    tally_and_finish();
  end
endmodule

bind sbmx_block_move sbmx_monitor sbmx_monitor_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_wr(mem_wr),
  .mem_ack(mem_ack), .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
  .scsi_req(scsi_req), .scsi_io(scsi_io), .scsi_ack(scsi_ack), .scsi_data_oe(scsi_data_oe));
